// *** rit_top.sv ***
// Refresh interval timer: registers, counter, compare and interrupts
//
// The implementer's own choices: the plain strobed port and the address map.
`timescale 1ns/1ns
module rit_top (
  input  wire logic                    core_clk,
  input  wire logic                    rst_n,
  input  wire logic [rit_pkg::AW-1:0]  reg_addr,
  input  wire logic [rit_pkg::DW-1:0]  reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [rit_pkg::DW-1:0]  reg_rdata,
  input  wire logic                    sleep_mode,
  input  wire logic                    hw_standby,
  input  wire logic                    sw_standby,
  output logic                         match_interrupt,
  output logic                         irq
);

  typedef struct packed {
    logic [rit_pkg::DW-1:0]    count;
    logic [rit_pkg::DW-1:0]    tconst;
    logic                      match_flag;
    logic                      irq_en;
    logic [rit_pkg::CKS_W-1:0] cks;
    logic [rit_pkg::DAS_W-1:0] das;
    logic [rit_pkg::DW-1:0]    rdata;
  } rit_state_t;

  localparam rit_state_t ST_RST = '{
    count:      rit_pkg::COUNT_RST,
    tconst:     rit_pkg::CONST_RST,
    match_flag: 1'b0,
    irq_en:     1'b0,
    cks:        rit_pkg::CKS_HALT,
    das:        rit_pkg::DAS_NONE,
    rdata:      rit_pkg::RD_ZERO
  };

  rit_state_t                st_ff;
  rit_state_t                nxt_st;
  logic [1:0]                rst_pipe_ff;
  logic                      rst_sync_n;
  logic                      interval_mode;
  logic                      run;
  logic                      count_pulse;
  logic                      inc;
  logic                      at_match;
  logic                      match;
  logic                      wr_ok;
  logic                      wr_cs;
  logic                      wr_count;
  logic                      wr_const;
  logic                      wr_dram;
  logic                      wr_mask;
  logic                      rd_status;
  logic [rit_pkg::IRQ_W-1:0] irq_status;
  logic [rit_pkg::IRQ_W-1:0] irq_mask;
  logic [rit_pkg::IRQ_W-1:0] irq_ev;
  logic [rit_pkg::DW-1:0]    cs_view;

  // Reset release through two flip-flops
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_pipe_ff <= 2'h0;
    end else begin
      rst_pipe_ff <= {rst_pipe_ff[0], 1'b1};
    end
  end

  assign rst_sync_n = rst_pipe_ff[1];

  // Mode and run conditions
  assign interval_mode = (st_ff.das == rit_pkg::DAS_NONE);
  // Sleep does not stop the timer; both standby modes do
  assign run = !hw_standby && !sw_standby;

  // Write decode; writes are ignored in hardware standby only
  assign wr_ok    = reg_wr && !hw_standby;
  assign wr_cs    = rit_pkg::hit(wr_ok, reg_addr, rit_pkg::ADDR_CTRL_STATUS);
  assign wr_count = rit_pkg::hit(wr_ok, reg_addr, rit_pkg::ADDR_COUNT);
  assign wr_const = rit_pkg::hit(wr_ok, reg_addr, rit_pkg::ADDR_CONST);
  assign wr_dram  = rit_pkg::hit(wr_ok, reg_addr, rit_pkg::ADDR_DRAM_CTRL);
  assign wr_mask  = rit_pkg::hit(wr_ok, reg_addr, rit_pkg::ADDR_IRQ_MASK);
  assign rd_status = rit_pkg::hit(reg_rd, reg_addr, rit_pkg::ADDR_IRQ_STATUS);

  // Count clock source
  rit_prescaler rit_prescaler_inst (
    .core_clk    (core_clk),
    .rst_sync_n  (rst_sync_n),
    .run         (run),
    .cks         (st_ff.cks),
    .count_pulse (count_pulse)
  );

  // Increment only in interval mode, on each count pulse (also at a switch from a high source to halted)
  assign inc = count_pulse && interval_mode;

  // Compare on the step away from the matching value
  assign at_match = (st_ff.count == st_ff.tconst);
  assign match    = inc && at_match && !wr_const;

  // Control/status view: flag, enable, select, low bits zero
  always_comb begin
    cs_view                                          = rit_pkg::RD_ZERO;
    cs_view[rit_pkg::CS_MATCH_FLAG]                  = st_ff.match_flag;
    cs_view[rit_pkg::CS_IRQ_EN]                      = st_ff.irq_en;
    cs_view[rit_pkg::CS_CKS_LSB +: rit_pkg::CKS_W]   = st_ff.cks;
  end

  // Next state of the timer and register file
  always_comb begin
    nxt_st = st_ff;

    // Control/status write: flag cleared by writing zero
    if (wr_cs) begin
      nxt_st.irq_en = reg_wdata[rit_pkg::CS_IRQ_EN];
      nxt_st.cks    = reg_wdata[rit_pkg::CS_CKS_LSB +: rit_pkg::CKS_W];
      if (!reg_wdata[rit_pkg::CS_MATCH_FLAG]) begin
        nxt_st.match_flag = 1'b0;
      end
    end
    if (wr_const) begin
      nxt_st.tconst = reg_wdata;
    end
    if (wr_dram) begin
      nxt_st.das = reg_wdata[rit_pkg::DAS_LSB +: rit_pkg::DAS_W];
    end

    // Match sets the flag; set beats a same-cycle clear
    if (match) begin
      nxt_st.match_flag = 1'b1;
    end

    // Counter: clear beats write, write beats increment
    if (match) begin
      nxt_st.count = rit_pkg::COUNT_RST;
    end else if (wr_count) begin
      nxt_st.count = reg_wdata;
    end else if (inc) begin
      nxt_st.count = st_ff.count + rit_pkg::COUNT_ONE;
    end

    // Software standby reinitialises counter, flag and enable
    if (sw_standby && !hw_standby) begin
      nxt_st.count      = rit_pkg::COUNT_RST;
      nxt_st.match_flag = 1'b0;
      nxt_st.irq_en     = 1'b0;
    end

    // Read data for the next cycle only
    nxt_st.rdata = rit_pkg::RD_ZERO;
    if (reg_rd) begin
      case (reg_addr)
        rit_pkg::ADDR_CTRL_STATUS: begin
          nxt_st.rdata = cs_view;
        end
        rit_pkg::ADDR_COUNT: begin
          nxt_st.rdata = st_ff.count;
        end
        rit_pkg::ADDR_CONST: begin
          nxt_st.rdata = st_ff.tconst;
        end
        rit_pkg::ADDR_DRAM_CTRL: begin
          nxt_st.rdata[rit_pkg::DAS_LSB +: rit_pkg::DAS_W] = st_ff.das;
        end
        rit_pkg::ADDR_IRQ_STATUS: begin
          nxt_st.rdata[rit_pkg::IRQ_W-1:0] = irq_status;
        end
        rit_pkg::ADDR_IRQ_MASK: begin
          nxt_st.rdata[rit_pkg::IRQ_W-1:0] = irq_mask;
        end
        default: begin
          nxt_st.rdata = rit_pkg::RD_ZERO;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st_ff <= ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Sticky interrupt status for match events
  always_comb begin
    irq_ev                         = '0;
    irq_ev[rit_pkg::IRQ_MATCH_BIT] = match;
  end

  rit_irq rit_irq_inst (
    .core_clk   (core_clk),
    .rst_sync_n (rst_sync_n),
    .ev         (irq_ev),
    .status_rd  (rd_status),
    .mask_wr    (wr_mask),
    .mask_wdata (reg_wdata[rit_pkg::IRQ_W-1:0]),
    .status     (irq_status),
    .mask       (irq_mask),
    .irq        (irq)
  );

  // Outputs
  assign reg_rdata       = st_ff.rdata;
  assign match_interrupt = st_ff.match_flag && st_ff.irq_en;

  // Checks
  // Match sets the flag
  a_flag_on_match : assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    (match && !sw_standby) |=> st_ff.match_flag)
    else $error("match did not set flag");

  // Flag rises only on a step off equality
  a_flag_rise_cause : assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    $rose(st_ff.match_flag) |-> $past(inc) && $past(at_match))
    else $error("flag rose without stepping off a match");

  // Match returns the counter to zero
  a_match_clears : assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    match |=> (st_ff.count == rit_pkg::COUNT_RST))
    else $error("match did not clear counter");

  // Clear wins over a counter write
  a_clear_beats_wr : assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    (match && wr_count && reg_wdata != rit_pkg::COUNT_RST) |=>
      (st_ff.count == rit_pkg::COUNT_RST))
    else $error("counter write beat a clear");

  // Counter write wins over an increment
  a_wr_beats_inc : assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    (wr_count && inc && !match && !sw_standby) |=> (st_ff.count == $past(reg_wdata)))
    else $error("increment not lost on counter write");

  // Constant write suppresses a match
  a_const_wr_inhibit : assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    (inc && at_match && wr_const && !sw_standby) |=>
      (st_ff.match_flag == $past(st_ff.match_flag)) &&
      (st_ff.tconst == $past(reg_wdata)))
    else $error("match not suppressed by constant write");

  // Dram space selected: counter frozen
  a_dram_mode_hold : assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    (!interval_mode && !wr_count && !sw_standby) |=> $stable(st_ff.count))
    else $error("counter moved while dram space is selected");

  // Hardware standby freezes the timer
  a_hw_standby_hold : assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    hw_standby |=> $stable(st_ff.count) && $stable(st_ff.tconst) && $stable(st_ff.cks))
    else $error("timer changed in hardware standby");

  // Software standby reinitialises part of the state
  a_sw_standby_init : assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    (sw_standby && !hw_standby && !wr_ok) |=>
      (st_ff.count == rit_pkg::COUNT_RST) && !st_ff.match_flag && !st_ff.irq_en &&
      $stable(st_ff.cks) && $stable(st_ff.tconst))
    else $error("software standby init wrong");

  // Enabled match raises the interrupt
  a_irq_gated : assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    (match && st_ff.irq_en && !wr_cs && !sw_standby) |=> match_interrupt)
    else $error("enabled match did not raise interrupt");

  // Halted source gives no count
  a_halted_no_inc : assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    (st_ff.cks == rit_pkg::CKS_HALT && $stable(st_ff.cks)) |-> !inc)
    else $error("halted source produced a count");

  // Sleep leaves the count running
  a_sleep_counts : assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    (sleep_mode && inc && !match && !wr_count && !sw_standby) |=>
      (st_ff.count == $past(st_ff.count) + rit_pkg::COUNT_ONE))
    else $error("counter stalled in sleep mode");

  // Each count pulse steps the counter once
  a_pulse_steps : assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    (inc && !match && !wr_count && !sw_standby) |=>
      (st_ff.count == $past(st_ff.count) + rit_pkg::COUNT_ONE))
    else $error("count pulse did not step the counter");

  // No pulse and no write: counter holds
  a_no_pulse_hold : assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    (!inc && !wr_count && !sw_standby) |=> $stable(st_ff.count))
    else $error("counter moved without a count pulse");

  // Equality without a pulse leaves the flag alone
  a_equal_no_flag : assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    (at_match && !inc && !st_ff.match_flag) |=> !st_ff.match_flag)
    else $error("flag set at equality without a count pulse");

  // Flag drops only by a zero write or software standby
  a_flag_clear_cause : assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    $fell(st_ff.match_flag) |->
      (($past(wr_cs) && !$past(reg_wdata[rit_pkg::CS_MATCH_FLAG])) || $past(sw_standby)))
    else $error("flag cleared without cause");

  // Match interrupt stays low while disabled
  a_irq_disabled : assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    !st_ff.irq_en |-> !match_interrupt)
    else $error("match interrupt raised while disabled");

  // Constant changes only by a write
  a_const_kept : assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    !wr_const |=> $stable(st_ff.tconst))
    else $error("time constant changed without a write");

  // Clock select changes only by a write
  a_cks_kept : assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    !wr_cs |=> $stable(st_ff.cks))
    else $error("clock select changed without a write");

  // Flag bit of the control/status read
  a_flag_read : assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    (reg_rd && reg_addr == rit_pkg::ADDR_CTRL_STATUS) |=>
      (reg_rdata[rit_pkg::CS_MATCH_FLAG] == $past(st_ff.match_flag)))
    else $error("flag missing from its read bit");

  // Read data stand for one cycle only
  a_rdata_idle : assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    !reg_rd |=> (reg_rdata == rit_pkg::RD_ZERO))
    else $error("read data outside a read answer");

  // Hardware standby blocks control writes
  a_hw_standby_no_wr : assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    hw_standby |=> $stable(st_ff.das) && $stable(st_ff.irq_en))
    else $error("control changed in hardware standby");

endmodule : rit_top

// *** rit_pkg.sv ***
// Constants shared by the refresh interval timer design
package rit_pkg;

  // Register port geometry
  localparam int AW = 4;
  localparam int DW = 8;

  // Register word addresses
  localparam logic [AW-1:0] ADDR_CTRL_STATUS = 4'h0;
  localparam logic [AW-1:0] ADDR_COUNT       = 4'h1;
  localparam logic [AW-1:0] ADDR_CONST       = 4'h2;
  localparam logic [AW-1:0] ADDR_DRAM_CTRL   = 4'h3;
  localparam logic [AW-1:0] ADDR_IRQ_STATUS  = 4'h4;
  localparam logic [AW-1:0] ADDR_IRQ_MASK    = 4'h5;

  // Control/status field positions
  localparam int CS_MATCH_FLAG = 7;
  localparam int CS_IRQ_EN     = 6;
  localparam int CS_CKS_LSB    = 3;
  localparam int CKS_W         = 3;

  // Dram control field position
  localparam int DAS_LSB = 5;
  localparam int DAS_W   = 3;

  // Reset and special values
  localparam logic [DW-1:0]    COUNT_RST = 8'h00;
  localparam logic [DW-1:0]    CONST_RST = 8'hFF;
  localparam logic [CKS_W-1:0] CKS_HALT  = 3'h0;
  localparam logic [DAS_W-1:0] DAS_NONE  = 3'h0;
  localparam logic [DW-1:0]    COUNT_ONE = 8'h01;
  localparam logic [DW-1:0]    RD_ZERO   = 8'h00;

  // Prescaler width: seven tapped divide-by-2^n sources
  localparam int PRESC_W = 7;
  localparam logic [PRESC_W-1:0] PRESC_ONE = 7'h01;
  localparam logic [PRESC_W-1:0] PRESC_RST = 7'h00;

  // Interrupt status layout
  localparam int IRQ_W         = 1;
  localparam int IRQ_MATCH_BIT = 0;
  localparam logic [IRQ_W-1:0] IRQ_RST = 1'h0;

  // Address hit test for a strobe
  function automatic logic hit(input logic strobe, input logic [AW-1:0] addr,
                               input logic [AW-1:0] target);
    hit = strobe && (addr == target);
  endfunction : hit

endpackage : rit_pkg

// *** rit_prescaler.sv ***
// Prescaler and falling-edge count pulse generator
`timescale 1ns/1ns
module rit_prescaler (
  input  wire logic                    core_clk,
  input  wire logic                    rst_sync_n,
  input  wire logic                    run,
  input  wire logic [rit_pkg::CKS_W-1:0] cks,
  output logic                         count_pulse
);

  typedef struct packed {
    logic [rit_pkg::PRESC_W-1:0] presc;
    logic                        level_prev;
  } rit_presc_t;

  rit_presc_t st_ff;
  rit_presc_t nxt_st;
  logic       sel_level;

  // Selected source level; halted setting reads low
  always_comb begin
    if (cks == rit_pkg::CKS_HALT) begin
      sel_level = 1'b0;
    end else begin
      sel_level = st_ff.presc[cks - 3'h1];
    end
  end

  // Falling edge of the selected source, also across a switchover
  assign count_pulse = run && st_ff.level_prev && !sel_level;

  // Divider advance and level history
  always_comb begin
    nxt_st = st_ff;
    if (run) begin
      nxt_st.presc      = st_ff.presc + rit_pkg::PRESC_ONE;
      nxt_st.level_prev = sel_level;
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st_ff <= '{presc: rit_pkg::PRESC_RST, level_prev: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Pulse only on a high to low step of the source
  a_pulse_on_fall : assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    count_pulse |=> !st_ff.level_prev)
    else $error("count pulse without a falling edge");

  // Steady select: pulses only when the tapped low bits wrap
  a_pulse_period : assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    (count_pulse && $past(run) && cks != rit_pkg::CKS_HALT && $stable(cks)) |->
      ((st_ff.presc & ((rit_pkg::PRESC_ONE << cks) - rit_pkg::PRESC_ONE)) ==
        rit_pkg::PRESC_RST))
    else $error("count pulse off the divider period");

  // Rewrite from a high source to halted counts once
  a_halt_switch_fall : assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    (run && $past(run) && cks == rit_pkg::CKS_HALT && $past(cks) != rit_pkg::CKS_HALT &&
      $past(sel_level)) |-> count_pulse)
    else $error("high to halted switch did not count");

endmodule : rit_prescaler

// *** rit_irq.sv ***
// Sticky interrupt status, mask and interrupt line
`timescale 1ns/1ns
module rit_irq (
  input  wire logic                    core_clk,
  input  wire logic                    rst_sync_n,
  input  wire logic [rit_pkg::IRQ_W-1:0] ev,
  input  wire logic                    status_rd,
  input  wire logic                    mask_wr,
  input  wire logic [rit_pkg::IRQ_W-1:0] mask_wdata,
  output logic      [rit_pkg::IRQ_W-1:0] status,
  output logic      [rit_pkg::IRQ_W-1:0] mask,
  output logic                         irq
);

  typedef struct packed {
    logic [rit_pkg::IRQ_W-1:0] status;
    logic [rit_pkg::IRQ_W-1:0] mask;
  } rit_irq_t;

  rit_irq_t st_ff;
  rit_irq_t nxt_st;

  // Read clears, a same-cycle event still sets
  always_comb begin
    nxt_st = st_ff;
    if (status_rd) begin
      nxt_st.status = '0;
    end
    nxt_st.status = nxt_st.status | ev;
    if (mask_wr) begin
      nxt_st.mask = mask_wdata;
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st_ff <= '{status: rit_pkg::IRQ_RST, mask: rit_pkg::IRQ_RST};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign status = st_ff.status;
  assign mask   = st_ff.mask;
  assign irq    = |(st_ff.status & st_ff.mask);

  a_read_clears : assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    (status_rd && ev == '0) |=> (status == '0 && !irq))
    else $error("status not cleared by read");

endmodule : rit_irq

// *** test_refresh_interval_timer.sv ***
// Self-checking bench for the refresh interval timer
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin \
  compares++; \
  if ((got) !== (exp)) begin \
    failures++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); \
  end \
end
module test_refresh_interval_timer;
  logic                     core_clk;
  logic                     rst_n;
  logic [rit_pkg::AW-1:0]   reg_addr;
  logic [rit_pkg::DW-1:0]   reg_wdata;
  logic                     reg_wr;
  logic                     reg_rd;
  logic [rit_pkg::DW-1:0]   reg_rdata;
  logic                     sleep_mode;
  logic                     hw_standby;
  logic                     sw_standby;
  logic                     match_interrupt;
  logic                     irq;
  logic [rit_pkg::DW-1:0]   rv;
  logic [rit_pkg::DW-1:0]   v;
  logic [rit_pkg::DW-1:0]   hold;
  int                       failures;
  int                       compares;

  rit_top rit_top_inst (
    .core_clk        (core_clk),
    .rst_n           (rst_n),
    .reg_addr        (reg_addr),
    .reg_wdata       (reg_wdata),
    .reg_wr          (reg_wr),
    .reg_rd          (reg_rd),
    .reg_rdata       (reg_rdata),
    .sleep_mode      (sleep_mode),
    .hw_standby      (hw_standby),
    .sw_standby      (sw_standby),
    .match_interrupt (match_interrupt),
    .irq             (irq)
  );

  // Expected control/status word
  function automatic logic [7:0] ctrl_val(input logic f, input logic e, input logic [2:0] c);
    ctrl_val = {f, e, c, 3'h0};
  endfunction : ctrl_val

  // Expected reset value of any word address
  function automatic logic [7:0] rst_val(input logic [3:0] a);
    rst_val = (a == rit_pkg::ADDR_CONST) ? rit_pkg::CONST_RST : rit_pkg::RD_ZERO;
  endfunction : rst_val

  // One write cycle
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  // Back-to-back writes of one word for n cycles
  task automatic wr_burst(input logic [3:0] a, input logic [7:0] d, input int n);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    repeat (n) @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask : wr_burst

  // One read cycle, data taken in the following cycle
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  // Bounded wait for irq (sel 0) or match_interrupt (sel 1)
  task automatic wait_for(input int n, input logic sel);
    int k;
    k = 0;
    while (((sel ? match_interrupt : irq) !== 1'b1) && (k < n)) begin
      @(posedge core_clk);
      #1;
      k++;
    end
  endtask : wait_for

  // Poll the counter until it leaves a value
  task automatic wait_step(input logic [7:0] old, input int n);
    int k;
    k = 0;
    rd(rit_pkg::ADDR_COUNT, rv);
    while ((rv === old) && (k < n)) begin
      rd(rit_pkg::ADDR_COUNT, rv);
      k++;
    end
  endtask : wait_step

  // Verdict and end of run
  task automatic end_of_test();
    $display("compares %0d failures %0d", compares, failures);
    if ((failures == 0) && (compares > 0)) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test

  // Clock at 125 MHz
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // Watchdog against a hang
  initial begin
    #400000;
    failures++;
    end_of_test();
  end

  // Main sequence
  initial begin
    failures = 0;
    compares = 0;
    rst_n = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    sleep_mode = 1'b0;
    hw_standby = 1'b0;
    sw_standby = 1'b0;
    void'($urandom(32'h6037d0cc));
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    // Reset values and unmapped words
    for (int a = 0; a < 16; a++) begin
      rd(a[3:0], rv);
      `CHK("reset value", rst_val(a[3:0]), rv)
    end
    // Random readback while halted, unmapped writes dropped
    for (int i = 0; i < 8; i++) begin
      v = $urandom;
      wr(rit_pkg::ADDR_CONST, v);
      wr(rit_pkg::ADDR_COUNT, ~v);
      wr(4'h6 + 4'($urandom % 10), 8'h5A);
      rd(rit_pkg::ADDR_CONST, rv);
      `CHK("constant", v, rv)
      rd(rit_pkg::ADDR_COUNT, rv);
      `CHK("count", ~v, rv)
    end
    // Dram area selected: no counting
    wr(rit_pkg::ADDR_DRAM_CTRL, 8'(($urandom % 7) + 1) << 5);
    wr(rit_pkg::ADDR_CONST, 8'hFF);
    wr(rit_pkg::ADDR_COUNT, 8'h00);
    wr(rit_pkg::ADDR_CTRL_STATUS, ctrl_val(1'b0, 1'b0, 3'h1));
    repeat (40) @(posedge core_clk);
    rd(rit_pkg::ADDR_COUNT, rv);
    `CHK("count dram on", 8'h00, rv)
    // Timer mode, sleep active: counts every 2 cycles
    sleep_mode <= 1'b1;
    wr(rit_pkg::ADDR_DRAM_CTRL, 8'h00);
    repeat (40) @(posedge core_clk);
    rd(rit_pkg::ADDR_COUNT, rv);
    `CHK("count sleep", 1'b1, rv inside {[8'd18 : 8'd23]})
    // Hardware standby freezes count and drops writes
    @(posedge core_clk);
    hw_standby <= 1'b1;
    rd(rit_pkg::ADDR_COUNT, hold);
    repeat (30) @(posedge core_clk);
    wr(rit_pkg::ADDR_COUNT, 8'h55);
    rd(rit_pkg::ADDR_COUNT, rv);
    `CHK("count hw standby", hold, rv)
    @(posedge core_clk);
    hw_standby <= 1'b0;
    sleep_mode <= 1'b0;
    // Switchover low to halted: no extra count
    wr(rit_pkg::ADDR_CTRL_STATUS, 8'h00);
    wr(rit_pkg::ADDR_COUNT, 8'h00);
    wr(rit_pkg::ADDR_CTRL_STATUS, ctrl_val(1'b0, 1'b0, 3'h7));
    wait_step(8'h00, 100);
    repeat (20) @(posedge core_clk);
    wr(rit_pkg::ADDR_CTRL_STATUS, 8'h00);
    rd(rit_pkg::ADDR_COUNT, rv);
    `CHK("low to halt", 8'h01, rv)
    // Switchover high to halted: counts once
    wr(rit_pkg::ADDR_CTRL_STATUS, ctrl_val(1'b0, 1'b0, 3'h7));
    wait_step(8'h01, 100);
    repeat (90) @(posedge core_clk);
    wr(rit_pkg::ADDR_CTRL_STATUS, 8'h00);
    rd(rit_pkg::ADDR_COUNT, rv);
    `CHK("high to halt", 8'h03, rv)
    repeat (20) @(posedge core_clk);
    rd(rit_pkg::ADDR_COUNT, rv);
    `CHK("halted", 8'h03, rv)
    // Equality alone sets no flag; match on stepping away
    v = 8'($urandom % 255) + 8'h01;
    wr(rit_pkg::ADDR_IRQ_MASK, 8'h01);
    wr(rit_pkg::ADDR_CONST, v);
    wr(rit_pkg::ADDR_COUNT, v);
    rd(rit_pkg::ADDR_CTRL_STATUS, rv);
    `CHK("flag at equality", ctrl_val(1'b0, 1'b0, 3'h0), rv)
    wr(rit_pkg::ADDR_CTRL_STATUS, ctrl_val(1'b0, 1'b0, 3'h7));
    wait_for(300, 1'b0);
    `CHK("irq", 1'b1, irq)
    rd(rit_pkg::ADDR_COUNT, rv);
    `CHK("count cleared", 8'h00, rv)
    rd(rit_pkg::ADDR_CTRL_STATUS, rv);
    `CHK("flag set", ctrl_val(1'b1, 1'b0, 3'h7), rv)
    `CHK("mi disabled", 1'b0, match_interrupt)
    wr(rit_pkg::ADDR_CTRL_STATUS, ctrl_val(1'b1, 1'b1, 3'h0));
    #1;
    `CHK("mi enabled", 1'b1, match_interrupt)
    rd(rit_pkg::ADDR_IRQ_STATUS, rv);
    `CHK("irq status", 8'h01, rv)
    rd(rit_pkg::ADDR_IRQ_STATUS, rv);
    `CHK("irq status cleared", 8'h00, rv)
    `CHK("irq low", 1'b0, irq)
    wr(rit_pkg::ADDR_CTRL_STATUS, ctrl_val(1'b0, 1'b1, 3'h0));
    #1;
    `CHK("flag cleared", 1'b0, match_interrupt)
    // Masked event: status sticky, irq low
    wr(rit_pkg::ADDR_IRQ_MASK, 8'h00);
    wr(rit_pkg::ADDR_CONST, 8'h02);
    wr(rit_pkg::ADDR_COUNT, 8'h00);
    wr(rit_pkg::ADDR_CTRL_STATUS, ctrl_val(1'b0, 1'b1, 3'h1));
    wait_for(50, 1'b1);
    `CHK("mi masked", 1'b1, match_interrupt)
    `CHK("masked irq", 1'b0, irq)
    wr(rit_pkg::ADDR_CTRL_STATUS, 8'h00);
    rd(rit_pkg::ADDR_IRQ_STATUS, rv);
    `CHK("masked status", 8'h01, rv)
    // Constant written every cycle: every match suppressed
    wr(rit_pkg::ADDR_COUNT, 8'h00);
    wr(rit_pkg::ADDR_CTRL_STATUS, ctrl_val(1'b0, 1'b0, 3'h1));
    wr_burst(rit_pkg::ADDR_CONST, 8'h04, 40);
    wr(rit_pkg::ADDR_CTRL_STATUS, ctrl_val(1'b1, 1'b0, 3'h0));
    rd(rit_pkg::ADDR_CTRL_STATUS, rv);
    `CHK("flag suppressed", 8'h00, rv)
    rd(rit_pkg::ADDR_COUNT, rv);
    `CHK("count passed", 1'b1, rv > 8'h10)
    // Count written every cycle at the constant: matches still fire
    wr(rit_pkg::ADDR_CTRL_STATUS, ctrl_val(1'b0, 1'b0, 3'h1));
    wr_burst(rit_pkg::ADDR_COUNT, 8'h04, 20);
    wr(rit_pkg::ADDR_CTRL_STATUS, ctrl_val(1'b1, 1'b0, 3'h0));
    rd(rit_pkg::ADDR_CTRL_STATUS, rv);
    `CHK("flag on count write", ctrl_val(1'b1, 1'b0, 3'h0), rv)
    // Software standby clears count, flag and enable only
    wr(rit_pkg::ADDR_CONST, 8'h33);
    wr(rit_pkg::ADDR_COUNT, 8'h33);
    wr(rit_pkg::ADDR_CTRL_STATUS, ctrl_val(1'b0, 1'b1, 3'h1));
    wait_for(50, 1'b1);
    `CHK("mi before standby", 1'b1, match_interrupt)
    @(posedge core_clk);
    sw_standby <= 1'b1;
    repeat (4) @(posedge core_clk);
    rd(rit_pkg::ADDR_CTRL_STATUS, rv);
    `CHK("ctrl sw standby", ctrl_val(1'b0, 1'b0, 3'h1), rv)
    rd(rit_pkg::ADDR_COUNT, rv);
    `CHK("count sw standby", 8'h00, rv)
    rd(rit_pkg::ADDR_CONST, rv);
    `CHK("const sw standby", 8'h33, rv)
    `CHK("mi sw standby", 1'b0, match_interrupt)
    @(posedge core_clk);
    sw_standby <= 1'b0;
    repeat (4) @(posedge core_clk);
    end_of_test();
  end
endmodule : test_refresh_interval_timer
